// file: hcsbd_pkg.sv
/*
 * hcsbd_pkg: shared types and constants of the chip-select bank decoder.
 * Assumes a single 40 MHz clock domain and a plain register port.
 */
package hcsbd_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic [2:0]  fc;
        logic        rd;
        logic        iack;
        logic [2:0]  lvl;
        logic [3:0]  be;
    } hcsbd_req_t;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_DELAY  = 3'b001,
        S_ACTIVE = 3'b010,
        S_HOLD   = 3'b011
    } hcsbd_state_t;

    localparam logic [7:0]  REG_GMR     = 8'h00;
    localparam logic [7:0]  REG_FLT     = 8'h04;
    localparam logic [7:0]  REG_IBB     = 8'h08;
    localparam logic [7:0]  REG_MCFG    = 8'h0c;
    localparam logic [7:0]  REG_PEP     = 8'h10;
    localparam logic [7:0]  REG_BANK    = 8'h40;
    localparam logic [31:0] GMR_RST     = 32'h0000_0003;
    localparam logic [31:0] BR0_RST     = 32'h0000_0001;
    localparam logic [31:0] OR0_RST     = 32'hf000_0003;
    localparam logic [31:0] BR_RST      = 32'h0000_0000;
    localparam logic [31:0] OR_RST      = 32'h0000_0000;
    localparam logic [31:0] IBB_RST     = 32'h0000_0000;
    localparam logic [31:0] MCFG_RST    = 32'h0000_0000;
    localparam logic [31:0] PEP_RST     = 32'h0000_0000;
    localparam int          GMR_ACK_LO  = 0;
    localparam int          GMR_PARITY_BUSERR_ENABLE    = 2;
    localparam int          BR_V        = 0;
    localparam int          BR_PAR      = 1;
    localparam int          BR_DLY      = 2;
    localparam int          BR_REL      = 3;
    localparam int          BR_WP       = 4;
    localparam int          FC_LO       = 8;
    localparam int          OR_PS_LO    = 0;
    localparam int          OR_DS       = 2;
    localparam int          OR_AM_LO    = 11;
    localparam int          OR_TC_LO    = 28;
    localparam int          IBB_V       = 0;
    localparam int          IBB_LO      = 13;
    localparam int          IBB_HALF    = 12;
    localparam int          MCFG_BUS_SIGNAL_SYNC_SEL   = 0;
    localparam int          MCFG_ARB_SIGNAL_SYNC_SEL   = 1;
    localparam int          PEP_AV      = 0;
    localparam int          PEP_WE      = 7;
    localparam logic [1:0]  ACK_EXT     = 2'b11;
    localparam logic [7:0]  VEC_BASE    = 8'h18;
    localparam logic [2:0]  STRAP_WAIT  = 3'd5;
endpackage : hcsbd_pkg

// file: hcsbd_top.sv
/*
 * hcsbd_top: chip-select bank decoder with internal block relocation,
 * auto-vector handling and boot strap capture.
 * Assumes the host core drives req_in on clk_in; pins arrive asynchronously.
 */
// Implementation choices: the plain strobed port and the address map.
// Overview of operation
// [RULE_01] self-vector during interrupt acknowledge ends cycle with internal vector
// [RULE_02] self-vector input ignored in every other cycle
// [RULE_03] eight bank selects; bank 0 is the boot select after reset
// [RULE_04] internal 8-KB block relocated by internal block base register
// [RULE_05] lower 4-KB half is RAM, upper half is registers
// [RULE_06] internal block base used only while its lsb is one
// [RULE_07] one fault report register holds write-protect and parity faults
// [RULE_08] acknowledge source 11 waits for external size acknowledge
// [RULE_09] parity bus-error enable clear suppresses bus error on parity
// [RULE_10] eight identical base/option register pairs, one per bank
// [RULE_11] select release bit holds select one extra cycle on writes
// [RULE_12] cycle start delay bit postpones select by one cycle
// [RULE_13] parity check off means no parity fault for that bank
// [RULE_14] bank decodes only while its valid bit is one
// [RULE_15] base bits 31..11 and function code compared to bus address
// [RULE_16] set mask bit includes address bit in compare, clear excludes
// [RULE_17] dynamic select zero means static handling; dynamic not served
// [RULE_18] port width 11 uses external size acknowledge
// [RULE_19] cycle clocks field sets access length in clocks
// [RULE_20] clear sync-select bits choose asynchronous sampling of signals
// [RULE_21] port E bit 7 routes byte write enables, bit 0 clear enables self-vector
// [RULE_22] strap pins latched: host mode, arbiter off, little endian
// [RULE_23] expansion bank select also serves as the data strobe
// [RULE_24] expansion ready supplies the size acknowledge ending the access
// [RULE_25] select only on valid unmasked hit, held until acknowledge
`timescale 1ns/1ps
module hcsbd_top (
    input  wire logic                 clk_in,            // 40 MHz clock
    input  wire logic                 nrst_in,           // async reset, low
    input  wire logic [7:0]           reg_addr_in,       // register byte address
    input  wire logic [31:0]          reg_wdata_in,      // register write data
    input  wire logic                 reg_wr_in,         // write strobe
    input  wire logic                 reg_rd_in,         // read strobe
    output logic [31:0]               reg_rdata_out,     // read data, next cycle
    input  wire hcsbd_pkg::hcsbd_req_t req_in,           // bus cycle request
    input  wire logic                 req_valid_in,      // request pulse
    output logic                      done_out,          // cycle end pulse
    output logic                      berr_out,          // bus error pulse
    output logic [7:0]                vector_out,        // internal vector
    output logic                      vector_valid_out,  // vector pulse
    output logic                      iram_sel_out,      // internal ram hit
    output logic                      ireg_sel_out,      // internal reg hit
    output logic [7:0]                bank_sel_n_out,    // bank selects, low
    output logic [3:0]                byte_we_n_out,     // byte write enables
    input  wire logic                 self_vector_n_in,  // auto-vector pin
    input  wire logic                 size_ack_n_in,     // size ack pin
    input  wire logic                 parity_err_in,     // parity fault pin
    input  wire logic [2:0]           strap_in,          // little_endian_strap, internal_arbiter_off, host_port_mode
    output logic                      host_port_mode_out,       // strap
    output logic                      internal_arbiter_off_out, // strap
    output logic                      little_endian_strap_out,  // strap
    output logic                      arb_sync_mode_out  // arbitration timing
);
    import hcsbd_pkg::*;

    hcsbd_state_t st_r;
    logic [31:0]  gmr_r;
    logic [31:0]  ibb_r;
    logic [31:0]  mcfg_r;
    logic [31:0]  pep_r;
    logic [15:0]  flt_r;
    logic [31:0]  br_r [8];
    logic [31:0]  or_r [8];
    logic [7:0]   bank_hit;
    logic [5:0]   pin_raw;
    logic [5:0]   s1_r;
    logic [5:0]   s2_r;
    logic [5:0]   s3_r;
    logic [5:0]   f_r;
    logic [5:0]   pin_v;
    logic [2:0]   boot_cnt_r;
    logic [2:0]   bank_r;
    logic         hit_r;
    logic         ext_r;
    logic         iack_r;
    logic         rd_r;
    logic         rel_r;
    logic         par_r;
    logic [2:0]   lvl_r;
    logic [3:0]   be_r;
    logic [3:0]   tcyc_r;
    logic [3:0]   cnt_r;
    logic         ib_hit;
    logic         bank_any;
    logic [2:0]   bank_idx;
    logic         wp_set;
    logic         par_set;
    logic         av_ok;
    logic         av_end;
    logic         end_c;
    logic [31:0]  rd_mux;
    logic [15:0]  flt_clr;

    // pin synchronisers; active-low pins inverted so reset means inactive
    assign pin_raw = {strap_in, parity_err_in, ~size_ack_n_in, ~self_vector_n_in};

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_sync
            always_ff @(posedge clk_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                    s3_r[g] <= 1'b0;
                    f_r[g]  <= 1'b0;
                end
                else
                begin
                    s1_r[g] <= pin_raw[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g])
                        f_r[g] <= s3_r[g];
                end
            end
            // synchronous timing takes the resynchronised level without filter
            assign pin_v[g] = mcfg_r[MCFG_BUS_SIGNAL_SYNC_SEL] ? s3_r[g] : f_r[g]; // [RULE_20]
        end

        for (g = 0; g < 8; g++) begin : g_bank
            always_ff @(posedge clk_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    br_r[g] <= (g == 0) ? BR0_RST : BR_RST; // [RULE_03]
                    or_r[g] <= (g == 0) ? OR0_RST : OR_RST;
                end
                else if (reg_wr_in && reg_addr_in[7:6] == REG_BANK[7:6] && reg_addr_in[5:3] == 3'(g))
                begin
                    if (reg_addr_in[2])
                        or_r[g] <= reg_wdata_in; // [RULE_10]
                    else
                        br_r[g] <= reg_wdata_in; // [RULE_10]
                end
            end
            assign bank_hit[g] = br_r[g][BR_V] // [RULE_14]
                && (((req_in.addr ^ br_r[g]) & {4'hf, or_r[g][27:OR_AM_LO], 11'h000}) == 32'h0) // [RULE_15] [RULE_16]
                && (((req_in.fc ^ br_r[g][FC_LO+2:FC_LO]) & or_r[g][FC_LO+2:FC_LO]) == 3'h0);
        end
    endgenerate

    // lowest bank index wins on overlapping regions
    always_comb
    begin
        bank_any = 1'b0;
        bank_idx = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (bank_hit[i])
            begin
                bank_any = 1'b1;
                bank_idx = 3'(i);
            end
        end
    end

    assign ib_hit = ibb_r[IBB_V] && req_in.addr[31:IBB_LO] == ibb_r[31:IBB_LO]; // [RULE_04] [RULE_06]
    assign wp_set = st_r == S_IDLE && req_valid_in && !ib_hit && bank_any
                    && br_r[bank_idx][BR_WP] && !req_in.rd;
    assign av_ok  = iack_r && !pep_r[PEP_AV] && pin_v[0]; // [RULE_01] [RULE_02] [RULE_21]
    assign av_end = st_r == S_ACTIVE && av_ok;
    // ready from the expansion bus is the size acknowledge
    assign end_c  = av_ok || (hit_r && (ext_r ? pin_v[1] : // [RULE_24]
                    ({1'b0, cnt_r} + 5'd1 >= {1'b0, tcyc_r}))); // [RULE_19]
    assign par_set = st_r == S_ACTIVE && end_c && !av_ok && hit_r && rd_r
                     && par_r && pin_v[2]; // [RULE_13]

    // bus cycle sequencer
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_r             <= S_IDLE;
            bank_r           <= 3'h0;
            hit_r            <= 1'b0;
            ext_r            <= 1'b0;
            iack_r           <= 1'b0;
            rd_r             <= 1'b1;
            rel_r            <= 1'b0;
            par_r            <= 1'b0;
            lvl_r            <= 3'h0;
            be_r             <= 4'h0;
            tcyc_r           <= 4'h0;
            cnt_r            <= 4'h0;
            done_out         <= 1'b0;
            berr_out         <= 1'b0;
            vector_out       <= 8'h00;
            vector_valid_out <= 1'b0;
            iram_sel_out     <= 1'b0;
            ireg_sel_out     <= 1'b0;
            bank_sel_n_out   <= 8'hff;
            byte_we_n_out    <= 4'hf;
        end
        else
        begin
            done_out         <= 1'b0;
            berr_out         <= 1'b0;
            vector_valid_out <= 1'b0;
            iram_sel_out     <= 1'b0;
            ireg_sel_out     <= 1'b0;
            case (st_r)
                S_IDLE:
                begin
                    if (req_valid_in)
                    begin
                        bank_r <= bank_idx;
                        iack_r <= req_in.iack;
                        rd_r   <= req_in.rd;
                        lvl_r  <= req_in.lvl;
                        be_r   <= req_in.be;
                        cnt_r  <= 4'h0;
                        hit_r  <= 1'b0;
                        rel_r  <= br_r[bank_idx][BR_REL];
                        par_r  <= br_r[bank_idx][BR_PAR];
                        tcyc_r <= or_r[bank_idx][OR_TC_LO+3:OR_TC_LO];
                        ext_r  <= gmr_r[GMR_ACK_LO+1:GMR_ACK_LO] == ACK_EXT // [RULE_08]
                                  || or_r[bank_idx][OR_PS_LO+1:OR_PS_LO] == ACK_EXT; // [RULE_18]
                        if (ib_hit)
                        begin
                            done_out     <= 1'b1;
                            iram_sel_out <= !req_in.addr[IBB_HALF]; // [RULE_05]
                            ireg_sel_out <= req_in.addr[IBB_HALF]; // [RULE_05]
                        end
                        else if (bank_any && !or_r[bank_idx][OR_DS] && !wp_set) // [RULE_17]
                        begin
                            hit_r <= 1'b1;
                            if (br_r[bank_idx][BR_DLY])
                                st_r <= S_DELAY; // [RULE_12]
                            else
                            begin
                                st_r           <= S_ACTIVE;
                                bank_sel_n_out <= ~(8'h01 << bank_idx); // [RULE_25] [RULE_23]
                                if (!req_in.rd && pep_r[PEP_WE])
                                    byte_we_n_out <= ~req_in.be; // [RULE_21]
                            end
                        end
                        else if (req_in.iack)
                            st_r <= S_ACTIVE;
                        else
                        begin
                            done_out <= 1'b1;
                            berr_out <= 1'b1;
                        end
                    end
                end
                S_DELAY:
                begin
                    st_r           <= S_ACTIVE;
                    bank_sel_n_out <= ~(8'h01 << bank_r); // [RULE_12] [RULE_25]
                    if (!rd_r && pep_r[PEP_WE])
                        byte_we_n_out <= ~be_r; // [RULE_21]
                end
                S_ACTIVE:
                begin
                    cnt_r <= cnt_r + 4'h1;
                    if (end_c)
                    begin
                        if (av_ok)
                        begin
                            vector_out       <= VEC_BASE + {5'h00, lvl_r}; // [RULE_01]
                            vector_valid_out <= 1'b1;
                        end
                        if (!av_ok && rel_r && !rd_r)
                            st_r <= S_HOLD; // [RULE_11]
                        else
                        begin
                            st_r           <= S_IDLE;
                            bank_sel_n_out <= 8'hff;
                            byte_we_n_out  <= 4'hf;
                            done_out       <= 1'b1;
                            berr_out       <= par_set && gmr_r[GMR_PARITY_BUSERR_ENABLE]; // [RULE_09]
                        end
                    end
                end
                S_HOLD:
                begin
                    st_r           <= S_IDLE;
                    bank_sel_n_out <= 8'hff;
                    byte_we_n_out  <= 4'hf;
                    done_out       <= 1'b1;
                end
                default:
                begin
                    st_r           <= S_IDLE;
                    bank_sel_n_out <= 8'hff;
                    byte_we_n_out  <= 4'hf;
                end
            endcase
        end
    end

    // global registers
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            gmr_r  <= GMR_RST;
            ibb_r  <= IBB_RST;
            mcfg_r <= MCFG_RST;
            pep_r  <= PEP_RST;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                REG_GMR:  gmr_r  <= reg_wdata_in;
                REG_IBB:  ibb_r  <= reg_wdata_in; // [RULE_04]
                REG_MCFG: mcfg_r <= reg_wdata_in;
                REG_PEP:  pep_r  <= reg_wdata_in;
                default:  gmr_r  <= gmr_r;
            endcase
        end
    end

    // fault report: write one clears, a new fault in the same cycle wins
    assign flt_clr = (reg_wr_in && reg_addr_in == REG_FLT) ? reg_wdata_in[15:0] : 16'h0000;

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            flt_r <= 16'h0000;
        else
            flt_r <= (flt_r & ~flt_clr) // [RULE_07]
                     | ({8'h00, wp_set ? (8'h01 << bank_idx) : 8'h00})
                     | ({par_set ? (8'h01 << bank_r) : 8'h00, 8'h00});
    end

    // strap capture once the filtered pins have settled after release
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            boot_cnt_r               <= 3'h0;
            host_port_mode_out       <= 1'b0;
            internal_arbiter_off_out <= 1'b0;
            little_endian_strap_out  <= 1'b0;
        end
        else if (boot_cnt_r != STRAP_WAIT)
        begin
            boot_cnt_r <= boot_cnt_r + 3'h1;
            if (boot_cnt_r == STRAP_WAIT - 3'h1)
            begin
                host_port_mode_out       <= f_r[3]; // [RULE_22]
                internal_arbiter_off_out <= f_r[4]; // [RULE_22]
                little_endian_strap_out  <= f_r[5]; // [RULE_22]
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            arb_sync_mode_out <= 1'b0;
        else
            arb_sync_mode_out <= mcfg_r[MCFG_ARB_SIGNAL_SYNC_SEL]; // [RULE_20]
    end

    // read path, unmapped reads as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (reg_addr_in[7:6] == REG_BANK[7:6] && reg_addr_in[1:0] == 2'b00)
            rd_mux = reg_addr_in[2] ? or_r[reg_addr_in[5:3]] : br_r[reg_addr_in[5:3]];
        else
        begin
            case (reg_addr_in)
                REG_GMR:  rd_mux = gmr_r;
                REG_FLT:  rd_mux = {16'h0000, flt_r};
                REG_IBB:  rd_mux = ibb_r;
                REG_MCFG: rd_mux = mcfg_r;
                REG_PEP:  rd_mux = pep_r;
                default:  rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (reg_rd_in)
            reg_rdata_out <= rd_mux;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence seq_delayed_start;
        st_r == S_IDLE ##1 st_r == S_DELAY;
    endsequence

    sequence seq_write_hold;
        st_r == S_ACTIVE && end_c && !rd_r ##1 st_r == S_HOLD;
    endsequence

    chk_sel_onehot: assert property ($onehot0(~bank_sel_n_out)) // [RULE_03]
    else $error("more than one bank select active");

    chk_av_only_iack: assert property (vector_valid_out |-> iack_r && done_out) // [RULE_02]
    else $error("auto-vector outside interrupt acknowledge");

    chk_av_vector: assert property (vector_valid_out |-> vector_out == VEC_BASE + {5'h00, lvl_r}) // [RULE_01]
    else $error("wrong auto-vector number");

    chk_ibb_valid: assert property ((iram_sel_out || ireg_sel_out) |-> $past(ibb_r[IBB_V])) // [RULE_06]
    else $error("internal block hit while base invalid");

    chk_half_split: assert property (iram_sel_out |-> !$past(req_in.addr[IBB_HALF]) && !ireg_sel_out) // [RULE_05]
    else $error("internal half decode wrong");

    chk_sel_valid: assert property ((bank_sel_n_out != 8'hff) |-> br_r[bank_r][BR_V] && hit_r) // [RULE_14]
    else $error("select without valid bank");

    chk_ext_wait: assert property (st_r == S_ACTIVE && hit_r && ext_r && !pin_v[1] && !av_ok |=> st_r == S_ACTIVE) // [RULE_08]
    else $error("cycle ended without size acknowledge");

    chk_delay_start: assert property (seq_delayed_start |=> st_r == S_ACTIVE && bank_sel_n_out != 8'hff) // [RULE_12]
    else $error("delayed start not one cycle");

    chk_write_hold: assert property (seq_write_hold |-> rel_r && bank_sel_n_out != 8'hff ##1 done_out) // [RULE_11]
    else $error("select hold wrong");

    chk_par_off: assert property ($rose(flt_r[8 + 0]) |-> $past(par_r)) // [RULE_13]
    else $error("parity fault with checking off");

    chk_we_route: assert property (byte_we_n_out != 4'hf |-> pep_r[PEP_WE] && !rd_r) // [RULE_21]
    else $error("byte enables driven while not routed");
endmodule : hcsbd_top

// file: hcsbd_exp_port.sv
/* expansion bus host-port responder for the bank decoder bench.
   assumes one select line and the host clock. */
`timescale 1ns/1ps
module hcsbd_exp_port (
    input  wire logic       clk_in,    // host clock
    input  wire logic       nrst_in,   // reset, low
    input  wire logic       cs_n_in,   // bank select, also strobe
    input  wire logic [3:0] wait_in,   // cycles before ready
    output logic            ack_n_out  // ready, pulled up
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            cnt_r <= 4'h0;
        else if (cs_n_in)
            cnt_r <= 4'h0;
        else if (cnt_r != 4'hf)
            cnt_r <= cnt_r + 4'h1;
    end
    // released ready is driven high, the pull-up level
    assign ack_n_out = !(!cs_n_in && cnt_r >= wait_in);
endmodule : hcsbd_exp_port

// file: tb_top.sv
/* self-checking bench for hcsbd_top.
   assumes a 40 MHz clock and the responder in hcsbd_exp_port. */
`timescale 1ns/1ps
module tb_top;
    import hcsbd_pkg::*;
    logic        clk_in = 0, nrst_in = 0, reg_wr_in = 0, reg_rd_in = 0;
    logic        req_valid_in = 0, self_vector_n_in = 1, ack_n, par_err = 0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
    logic [3:0]  wait_in = 4'h1, byte_we_n_out;
    hcsbd_req_t  req_in = '0;
    logic        done_out, berr_out, vector_valid_out, iram_sel_out, ireg_sel_out;
    logic        host_port_mode, internal_arbiter_off, little_endian_strap, arb_sync_mode_out;
    logic [7:0]  vector_out, bank_sel_n_out;
    int          failures = 0, checked = 0, cyc = 0;
    hcsbd_top i_hcsbd_top (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .req_in(req_in), .req_valid_in(req_valid_in),
        .done_out(done_out), .berr_out(berr_out), .vector_out(vector_out),
        .vector_valid_out(vector_valid_out), .iram_sel_out(iram_sel_out),
        .ireg_sel_out(ireg_sel_out), .bank_sel_n_out(bank_sel_n_out),
        .byte_we_n_out(byte_we_n_out), .self_vector_n_in(self_vector_n_in),
        .size_ack_n_in(ack_n), .parity_err_in(par_err), .strap_in(3'b110),
        .host_port_mode_out(host_port_mode), .internal_arbiter_off_out(internal_arbiter_off),
        .little_endian_strap_out(little_endian_strap), .arb_sync_mode_out(arb_sync_mode_out));
    hcsbd_exp_port i_hcsbd_exp_port (.clk_in(clk_in), .nrst_in(nrst_in),
        .cs_n_in(bank_sel_n_out[0]), .wait_in(wait_in), .ack_n_out(ack_n));
    always #12.5 clk_in = ~clk_in;
    task final_report;
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            final_report();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata_out);
    endtask : rd
    // flags: done, berr, iram, ireg, vector valid
    task acc(input logic [31:0] a, input logic r, ia, input logic [4:0] ef,
             input logic [7:0] es, input logic [3:0] ew);
        logic [4:0] f;
        logic [7:0] s;
        logic [3:0] w;
        f = 5'h0;
        s = 8'hff;
        w = 4'hf;
        @(posedge clk_in);
        req_in <= '{addr: a, fc: 3'h5, rd: r, iack: ia, lvl: 3'h3, be: 4'h5};
        req_valid_in <= 1'b1;
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        repeat (60)
        begin
            #1;
            if (bank_sel_n_out !== 8'hff)
            begin
                s = bank_sel_n_out;
                w = byte_we_n_out;
            end
            if (done_out === 1'b1 && f[4] !== 1'b1)
                f = {1'b1, berr_out, iram_sel_out, ireg_sel_out, vector_valid_out};
            @(posedge clk_in);
        end
        chk("flags", {27'h0, ef}, {27'h0, f});
        chk("select", {24'h0, es}, {24'h0, s});
        chk("write enables", {28'h0, ew}, {28'h0, w});
    endtask : acc
    initial
    begin
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        #1;
        chk("straps", 32'h6, {29'h0, little_endian_strap, internal_arbiter_off, host_port_mode});
        rd(REG_GMR, GMR_RST);
        rd(REG_BANK, BR0_RST);
        rd(REG_BANK + 8'h04, OR0_RST);
        wr(8'h3c, 32'hffff_ffff);
        rd(8'h3c, 32'h0);
        acc(32'h0900_0000, 1'b1, 1'b0, 5'h10, 8'hfe, 4'hf);
        wr(REG_PEP, 32'h80);
        wait_in <= 4'hc;
        acc(32'h0900_0004, 1'b0, 1'b0, 5'h10, 8'hfe, 4'ha);
        wr(REG_IBB, 32'h0000_2001);
        acc(32'h0000_2010, 1'b1, 1'b0, 5'h14, 8'hff, 4'hf);
        acc(32'h0000_3ffc, 1'b1, 1'b0, 5'h12, 8'hff, 4'hf);
        wr(REG_IBB, 32'h0000_2000);
        acc(32'h0000_2010, 1'b1, 1'b0, 5'h10, 8'hfe, 4'hf);
        self_vector_n_in <= 1'b0;
        acc(32'h0900_0008, 1'b1, 1'b0, 5'h10, 8'hfe, 4'hf);
        wr(REG_BANK, 32'h0);
        acc(32'h0900_0008, 1'b1, 1'b0, 5'h18, 8'hff, 4'hf);
        acc(32'hffff_fff0, 1'b1, 1'b1, 5'h11, 8'hff, 4'hf);
        chk("vector", {24'h0, VEC_BASE + 8'h03}, {24'h0, vector_out});
        self_vector_n_in <= 1'b1;
        wr(REG_MCFG, 32'h3);
        repeat (2) @(posedge clk_in);
        #1;
        chk("arb sync", 32'h1, {31'h0, arb_sync_mode_out});
        par_err <= 1'b1;
        wr(REG_BANK, 32'h0000_0001);
        acc(32'h0900_0000, 1'b1, 1'b0, 5'h10, 8'hfe, 4'hf);
        rd(REG_FLT, 32'h0);
        wr(REG_BANK, 32'h0000_0013);
        acc(32'h0900_0000, 1'b1, 1'b0, 5'h10, 8'hfe, 4'hf);
        acc(32'h0900_0004, 1'b0, 1'b0, 5'h18, 8'hff, 4'hf);
        rd(REG_FLT, 32'h0000_0101);
        wr(REG_GMR, 32'h7);
        acc(32'h0900_0000, 1'b1, 1'b0, 5'h18, 8'hfe, 4'hf);
        wr(REG_FLT, 32'hffff);
        rd(REG_FLT, 32'h0);
        par_err <= 1'b0;
        wr(REG_BANK, 32'h0000_000d);
        acc(32'h0900_0004, 1'b0, 1'b0, 5'h10, 8'hfe, 4'ha);
        wr(REG_BANK, 32'h0900_0501);
        wr(REG_BANK + 8'h04, 32'hffff_ff03);
        acc(32'h0900_0000, 1'b1, 1'b0, 5'h10, 8'hfe, 4'hf);
        acc(32'h0900_0800, 1'b1, 1'b0, 5'h18, 8'hff, 4'hf);
        wr(REG_BANK + 8'h04, 32'hffff_ff07);
        acc(32'h0900_0000, 1'b1, 1'b0, 5'h18, 8'hff, 4'hf);
        final_report();
    end
endmodule : tb_top
